//--- rfc_device.sv
`timescale 1ns/10ps
module rfc_device
    import rfc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Host link
    rfc_if.device link,
    // Store readback and busy flag for the user side
    input wire logic [7:0] peek_code_i,
    input wire logic [2:0] peek_slot_i,
    output logic [31:0] peek_data_o,
    output logic busy_o
);
    // Parser states; END is a one-cycle slot in which ready is low
    // and the verdict of the whole command is published
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ELEM = 3'b001,
        ST_QPAR = 3'b010,
        ST_DRAIN = 3'b011,
        ST_END = 3'b100
    } rfc_state_t;

    // All parser state; every link output is a copy kept in a flip-flop
    typedef struct packed {
        rfc_state_t state;
        logic [2:0] pos;
        logic [5:0] count;
        logic [7:0] code;
        logic [7:0] addr;
        logic [31:0] value;
        logic bad;
        logic wr_en;
        logic done;
        logic fault;
        logic rsp_valid;
        logic [7:0] rsp_byte;
        logic [31:0] peek;
        logic busy;
        logic ready;
    } rfc_dev_t;

    // Current and next copy of the state; store readback arrives combinationally
    rfc_dev_t r;
    rfc_dev_t next_r;
    logic [31:0] rd_data;
    logic take;

    // Codes fold to a flat index so the store holds only the valid sets;
    // writes are gated by the checks, so an invalid code never reaches it
    rfc_slot_store u_store (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(r.wr_en),
        .wr_code_i(rfc_code_index(r.code)),
        .wr_slot_i(r.addr[2:0]),
        .wr_data_i(r.value),
        .rd_code_i(rfc_code_index(peek_code_i)),
        .rd_slot_i(peek_slot_i),
        .rd_data_o(rd_data)
    );

    // A byte is taken in every state but END; the host holds it until then
    assign take = link.cmd_valid && (r.state != ST_END);
    assign link.cmd_ready = r.ready;
    assign link.done = r.done;
    assign link.fault = r.fault;
    assign link.rsp_valid = r.rsp_valid;
    assign link.rsp_byte = r.rsp_byte;
    assign peek_data_o = r.peek;
    assign busy_o = r.busy;

    // Command byte parser and element checker
    always_comb begin
        next_r = r;
        next_r.wr_en = 1'b0;
        next_r.done = 1'b0;
        next_r.fault = 1'b0;
        next_r.rsp_valid = 1'b0;
        // Readback of an invalid code shows zero, not a folded neighbour
        next_r.peek = rfc_code_ok(peek_code_i) ? rd_data : SLOT_RESET;
        unique case (r.state)
            ST_IDLE: begin
                if (take) begin
                    // Fresh command: position, count and verdict start over
                    next_r.pos = 3'h0;
                    next_r.count = 6'h00;
                    next_r.bad = 1'b0;
                    if (link.cmd_byte == CMD_STORE_WRITE) begin
                        // Command alone carries no element: too few
                        next_r.state = link.cmd_last ? ST_END : ST_ELEM;
                        next_r.bad = link.cmd_last;
                    end else if (link.cmd_byte == CMD_COUNT_QUERY) begin
                        next_r.state = link.cmd_last ? ST_END : ST_QPAR;
                        next_r.bad = link.cmd_last;
                    end else begin
                        // Unknown command: swallow the frame, then flag it
                        next_r.bad = 1'b1;
                        next_r.state = link.cmd_last ? ST_END : ST_DRAIN;
                    end
                end
            end
            ST_ELEM: begin
                if (take) begin
                    // Byte 0 of an element is its code, byte 1 the register address,
                    // bytes 2 to 5 the value; once bad is set, no later element
                    // is written either, but earlier ones stay in the store
                    next_r.pos = r.pos + 3'h1;
                    if (r.pos == 3'h0) begin
                        next_r.code = link.cmd_byte;
                        if (!rfc_code_ok(link.cmd_byte)) begin
                            next_r.bad = 1'b1;
                        end
                    end else if (r.pos == 3'h1) begin
                        next_r.addr = link.cmd_byte;
                        if (link.cmd_byte >= rfc_reg_count(r.code)) begin
                            next_r.bad = 1'b1;
                        end
                    end else begin
                        // Value bytes fill from the low end upward
                        next_r.value[8*(r.pos-3'h2) +: 8] = link.cmd_byte;
                    end
                    if (r.pos == ELEM_LAST_BYTE) begin
                        next_r.pos = 3'h0;
                        next_r.count = r.count + 6'h01;
                        // Elements after a failure are not written
                        next_r.wr_en = !r.bad && (r.count < ELEM_MAX_CNT);
                        if (r.count >= ELEM_MAX_CNT) begin
                            next_r.bad = 1'b1;
                        end
                    end
                    if (link.cmd_last) begin
                        // Partial element means value not four bytes long
                        if (r.pos != ELEM_LAST_BYTE) begin
                            next_r.bad = 1'b1;
                        end
                        next_r.state = ST_END;
                    end
                end
            end
            // Query takes exactly one parameter byte; more bytes make it fail
            // and the rest of the frame is drained before the verdict
            ST_QPAR: begin
                if (take) begin
                    next_r.code = link.cmd_byte;
                    if (!link.cmd_last || !rfc_code_ok(link.cmd_byte)) begin
                        next_r.bad = 1'b1;
                    end else begin
                        next_r.rsp_byte = rfc_reg_count(link.cmd_byte);
                    end
                    next_r.state = link.cmd_last ? ST_END : ST_DRAIN;
                end
            end
            // Rest of a refused frame is swallowed so the next command starts clean
            ST_DRAIN: begin
                if (take) begin
                    next_r.bad = 1'b1;
                    next_r.state = link.cmd_last ? ST_END : ST_DRAIN;
                end
            end
            ST_END: begin
                // One-cycle completion: exception or normal end
                next_r.fault = r.bad;
                next_r.done = !r.bad;
                // Only a clean query arrives with a count loaded and no element seen
                // Host sees the pulse one cycle later and lifts its block
                next_r.rsp_valid = !r.bad && (r.rsp_byte != 8'h00) && (r.pos == 3'h0) && (r.count == 6'h00);
                next_r.rsp_byte = r.rsp_byte;
                next_r.state = ST_IDLE;
            end
            default: begin
                // Unused codes fall back to idle rather than hang
                next_r.state = ST_IDLE;
            end
        endcase
        // A stale count from an earlier query must not answer a later write
        if (r.state == ST_IDLE && take) begin
            next_r.rsp_byte = 8'h00; // Cleared so a write never answers
        end
        // Status outputs follow the next state so they come straight from flops;
        // costs two flops but keeps decode glitches off the pins
        next_r.busy = (next_r.state != ST_IDLE);
        next_r.ready = (next_r.state != ST_END);
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Idle with ready high, so a byte may be taken at the first edge
            r <= '0;
            r.ready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
endmodule

//--- rfc_pkg.sv
package rfc_pkg;
    // Command bytes
    localparam logic [7:0] CMD_STORE_WRITE = 8'h13;
    localparam logic [7:0] CMD_COUNT_QUERY = 8'h14;
    // Configuration code ranges
    localparam logic [7:0] TX_CODE_MIN = 8'h00;
    localparam logic [7:0] TX_CODE_MAX = 8'h1C;
    localparam logic [7:0] RX_CODE_MIN = 8'h80;
    localparam logic [7:0] RX_CODE_MAX = 8'h9C;
    localparam logic [7:0] RX_CODE_OFFSET = 8'h80;
    localparam logic [7:0] ALL_SPEED_TARGET_TX = 8'h1C;
    // Element layout
    localparam int ELEM_MIN = 1;
    localparam int ELEM_MAX = 42;
    localparam logic [2:0] ELEM_BYTES = 3'h6;
    localparam logic [2:0] ELEM_LAST_BYTE = 3'h5;
    localparam logic [5:0] ELEM_MAX_CNT = 6'h2A;
    // Store geometry: 29 codes per direction, one slot array per code
    localparam int CODE_NUM = 58;
    localparam logic [5:0] RX_INDEX_BASE = 6'h1D;
    localparam int REG_SLOTS = 8;
    localparam logic [7:0] REG_COUNT_DEFAULT = 8'h08;
    localparam logic [31:0] SLOT_RESET = 32'h0000_0000;

    // Code is inside one of the two documented ranges
    function automatic logic rfc_code_ok(input logic [7:0] code);
        return (code <= TX_CODE_MAX) || (code >= RX_CODE_MIN && code <= RX_CODE_MAX);
    endfunction

    // Flat store index of a valid code
    function automatic logic [5:0] rfc_code_index(input logic [7:0] code);
        if (code >= RX_CODE_MIN) begin
            return 6'(code - RX_CODE_OFFSET) + RX_INDEX_BASE;
        end
        return 6'(code);
    endfunction

    // Register count per code; all valid codes hold the same slot count here, invalid codes give zero
    function automatic logic [7:0] rfc_reg_count(input logic [7:0] code);
        return rfc_code_ok(code) ? REG_COUNT_DEFAULT : 8'h00;
    endfunction
endpackage

//--- rfc_if.sv
`timescale 1ns/10ps
// Byte stream from host to device and answer back
interface rfc_if;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic cmd_last;
    logic cmd_ready;
    logic done;
    logic fault;
    logic rsp_valid;
    logic [7:0] rsp_byte;
    modport device (input cmd_valid, input cmd_byte, input cmd_last, output cmd_ready,
                    output done, output fault, output rsp_valid, output rsp_byte);
    modport host (output cmd_valid, output cmd_byte, output cmd_last, input cmd_ready,
                  input done, input fault, input rsp_valid, input rsp_byte);
endinterface

//--- rfc_slot_store.sv
`timescale 1ns/10ps
module rfc_slot_store
    import rfc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Write port
    input wire logic wr_en_i,
    input wire logic [5:0] wr_code_i,
    input wire logic [2:0] wr_slot_i,
    input wire logic [31:0] wr_data_i,
    // Read port
    input wire logic [5:0] rd_code_i,
    input wire logic [2:0] rd_slot_i,
    output logic [31:0] rd_data_o
);
    // Whole store as one flat word array, indexed by {code index, slot}
    typedef struct packed {
        logic [CODE_NUM*REG_SLOTS-1:0][31:0] slot;
    } rfc_store_t;

    rfc_store_t s;
    rfc_store_t next_s;
    logic [8:0] wr_idx;
    logic [8:0] rd_idx;

    assign wr_idx = {wr_code_i, wr_slot_i};
    assign rd_idx = {rd_code_i, rd_slot_i};
    assign rd_data_o = s.slot[rd_idx];

    // Only the addressed slot changes; every other entry keeps its value
    always_comb begin
        next_s = s;
        if (wr_en_i) begin
            next_s.slot[wr_idx] = wr_data_i;
        end
    end

    // Volatile model of the store: reset clears every slot
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= {(CODE_NUM*REG_SLOTS){SLOT_RESET}};
        end else begin
            s <= next_s;
        end
    end
endmodule

//--- rfc_host.sv
`timescale 1ns/10ps
module rfc_host
    import rfc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Host link
    rfc_if.host link,
    // User request: byte queue presented one at a time
    input wire logic req_valid_i,
    input wire logic [7:0] req_byte_i,
    input wire logic req_last_i,
    output logic req_ready_o,
    // Completion
    output logic done_o,
    output logic fault_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_byte_o
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_SEND = 2'b01,
        HS_WAIT = 2'b10
    } rfc_hstate_t;

    typedef struct packed {
        rfc_hstate_t state;
        logic done;
        logic fault;
        logic rsp_valid;
        logic [7:0] rsp_byte;
    } rfc_host_t;

    rfc_host_t h;
    rfc_host_t next_h;

    // Bytes pass straight through while sending; blocked while a command is open
    assign link.cmd_valid = req_valid_i && (h.state != HS_WAIT);
    assign link.cmd_byte = req_byte_i;
    assign link.cmd_last = req_last_i;
    assign req_ready_o = link.cmd_ready && (h.state != HS_WAIT);
    assign done_o = h.done;
    assign fault_o = h.fault;
    assign rsp_valid_o = h.rsp_valid;
    assign rsp_byte_o = h.rsp_byte;

    // Sequencer: a new command only after the previous one completed
    always_comb begin
        next_h = h;
        next_h.done = 1'b0;
        next_h.fault = 1'b0;
        next_h.rsp_valid = 1'b0;
        unique case (h.state)
            HS_IDLE, HS_SEND: begin
                if (link.cmd_valid && link.cmd_ready) begin
                    next_h.state = req_last_i ? HS_WAIT : HS_SEND;
                end
            end
            HS_WAIT: begin
                if (link.rsp_valid) begin
                    next_h.rsp_valid = 1'b1;
                    next_h.rsp_byte = link.rsp_byte;
                end
                if (link.done || link.fault) begin
                    next_h.done = link.done;
                    next_h.fault = link.fault;
                    next_h.state = HS_IDLE;
                end
            end
            default: begin
                next_h.state = HS_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            h <= '0;
        end else begin
            h <= next_h;
        end
    end
endmodule

//--- rfc_chk.sv
`timescale 1ns/10ps
module rfc_chk
    import rfc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Link signals
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic cmd_last,
    input wire logic cmd_ready,
    input wire logic done,
    input wire logic fault,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte
);
    logic ends;
    logic ok;
    logic qry;
    logic wr;
    logic [8:0] idx;
    logic [7:0] op;
    // Last byte taken; op only means something once idx is past the command byte
    assign ends = cmd_valid && cmd_ready && cmd_last;
    assign ok = cmd_byte <= TX_CODE_MAX || (cmd_byte >= RX_CODE_MIN && cmd_byte <= RX_CODE_MAX);
    assign qry = ends && idx == 9'h001 && op == CMD_COUNT_QUERY;
    assign wr = ends && idx != 9'h000 && op == CMD_STORE_WRITE;
    // Byte position within the open command
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idx <= 9'h000;
            op <= 8'h00;
        end else if (cmd_valid && cmd_ready) begin
            idx <= cmd_last ? 9'h000 : idx + 9'h001;
            op <= idx == 9'h000 ? cmd_byte : op;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_answer_on_time: assert property (ends |-> ##2 (done || fault)) else $error("no answer");
    a_no_stray_answer: assert property ((done || fault) |-> $past(ends, 2)) else $error("stray answer");
    a_answer_single: assert property ((done || fault) |=> !done && !fault) else $error("long answer");
    a_done_xor_fault: assert property (!(done && fault)) else $error("both answers");
    a_count_value: assert property (rsp_valid |-> done && rsp_byte == REG_COUNT_DEFAULT) else $error("bad count");
    a_query_answer: assert property (qry && ok |-> ##2 rsp_valid) else $error("no count");
    a_query_bad_code: assert property (qry && !ok |-> ##2 fault) else $error("bad code kept");
    a_write_partial: assert property (wr && idx % 9'h006 != 9'h000 |-> ##2 fault) else $error("partial kept");
    a_write_too_long: assert property (wr && idx > 9'h0FC |-> ##2 fault) else $error("too long kept");
    c_count: cover property (rsp_valid);
    c_fault: cover property (fault);
    c_write: cover property (wr ##2 done);
endmodule

//--- tb.sv
`timescale 1ns/10ps
module tb;
    import rfc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic [7:0] req_byte_i = 8'h00;
    logic req_last_i = 1'b0;
    logic [7:0] peek_code_i = 8'h00;
    logic [2:0] peek_slot_i = 3'h0;
    logic req_ready_o, done_o, fault_o, rsp_valid_o, busy_o;
    logic [7:0] rsp_byte_o;
    logic [31:0] peek_data_o;
    logic [7:0] cmd_q[$];
    logic [2:0] got;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    rfc_if u_rfc_if();
    rfc_host u_rfc_host(.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(u_rfc_if.host),
        .req_valid_i(req_valid_i), .req_byte_i(req_byte_i), .req_last_i(req_last_i), .req_ready_o(req_ready_o),
        .done_o(done_o), .fault_o(fault_o), .rsp_valid_o(rsp_valid_o), .rsp_byte_o(rsp_byte_o));
    rfc_device u_rfc_device(.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(u_rfc_if.device),
        .peek_code_i(peek_code_i), .peek_slot_i(peek_slot_i), .peek_data_o(peek_data_o), .busy_o(busy_o));
    rfc_chk u_rfc_chk(.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cmd_valid(u_rfc_if.cmd_valid),
        .cmd_byte(u_rfc_if.cmd_byte), .cmd_last(u_rfc_if.cmd_last), .cmd_ready(u_rfc_if.cmd_ready),
        .done(u_rfc_if.done), .fault(u_rfc_if.fault), .rsp_valid(u_rfc_if.rsp_valid), .rsp_byte(u_rfc_if.rsp_byte));
    // Clock, 4 ns period
    always #2 ref_clk_i = ~ref_clk_i;
    task automatic finish_test();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard: the whole run needs under a thousand cycles
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Sends cmd_q byte by byte, then takes {done, fault, rsp_valid} from the host
    task automatic send(input logic [2:0] exp);
        for (int i = 0; i < cmd_q.size(); i++) begin
            req_valid_i = 1'b1;
            req_byte_i = cmd_q[i];
            req_last_i = i == cmd_q.size() - 1;
            while (req_ready_o !== 1'b1) @(negedge ref_clk_i);
            @(negedge ref_clk_i);
        end
        req_valid_i = 1'b0;
        chk(32'(req_ready_o), 32'h00000000);
        got = 3'h0;
        for (int n = 0; n < 20 && got == 3'h0; n++) begin
            got = {done_o, fault_o, rsp_valid_o};
            @(negedge ref_clk_i);
        end
        chk(32'(got), 32'(exp));
        cmd_q = '{CMD_STORE_WRITE};
    endtask
    // Value goes out least significant byte first
    task automatic push(input logic [7:0] code, input logic [7:0] addr, input logic [31:0] val);
        cmd_q = {cmd_q, code, addr, val[7:0], val[15:8], val[23:16], val[31:24]};
    endtask
    // Readback answers one cycle after the select settles
    task automatic peek(input logic [7:0] code, input logic [2:0] slot, input logic [31:0] exp);
        peek_code_i = code;
        peek_slot_i = slot;
        @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(peek_data_o, exp);
    endtask
    initial begin
        logic [7:0] codes[8] = '{8'h00, 8'h1C, 8'h80, 8'h9C, 8'h1D, 8'h7F, 8'h9D, 8'hFF};
        repeat (12) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        @(negedge ref_clk_i);
        // Count query at both ends of each range, then just outside them and at FF
        foreach (codes[i]) begin
            cmd_q = '{CMD_COUNT_QUERY, codes[i]};
            send(i < 4 ? 3'h5 : 3'h2);
            if (i < 4) begin
                chk(32'(rsp_byte_o), 32'h00000008);
            end
        end
        cmd_q = '{CMD_COUNT_QUERY, 8'h80, 8'h00};
        send(3'h2);
        cmd_q = '{8'h15};
        send(3'h2);
        send(3'h2);
        push(8'h1C, 8'h07, 32'hA1B2C3D4);
        push(8'h80, 8'h00, 32'h11223344);
        send(3'h4);
        peek(8'h1C, 3'h7, 32'hA1B2C3D4);
        peek(8'h80, 3'h0, 32'h11223344);
        peek(8'h1C, 3'h6, 32'h00000000);
        peek(8'h9C, 3'h7, 32'h00000000);
        chk(32'(busy_o), 32'h00000000);
        // Bad code or address after a good element: fault, and the good one stays
        for (int j = 0; j < 6; j++) begin
            push(8'h05, 8'h02, 32'h0BAD0000 + 32'(j));
            push(j < 4 ? codes[j + 4] : 8'h1C, j < 4 ? 8'h00 : 8'h08 << (j - 4), 32'h00000000);
            send(3'h2);
            peek(8'h05, 3'h2, 32'h0BAD0000 + 32'(j));
        end
        // Element cut one byte short is not stored
        cmd_q = {cmd_q, 8'h04, 8'h01, 8'h78, 8'h56, 8'h34};
        send(3'h2);
        peek(8'h04, 3'h1, 32'h00000000);
        // Largest legal array, then one element over it
        for (int k = 0; k < 42; k++) begin
            push(8'h0A, 8'(k % 8), 32'h10000000 + 32'(k));
        end
        send(3'h4);
        peek(8'h0A, 3'h1, 32'h10000029);
        for (int k = 0; k < 43; k++) begin
            push(8'h0B, 8'h00, 32'h00000000);
        end
        send(3'h2);
        finish_test();
    end
endmodule
